// File: inc/nsr_params.svh
// Offsets, field positions, reset values and bus codes of the block
`ifndef NSR_PARAMS_SVH
`define NSR_PARAMS_SVH
// ==================================================================
// Register offsets
`define NSR_CTL_OFS 12'h000
`define NSR_GRP_BASE 12'h080
`define NSR_PERM_BASE 12'hE00
`define NSR_SGIR_OFS 12'hF00
// ==================================================================
// Request word fields, control enable bit and fields per register
`define NSR_ID_LSB 0
`define NSR_ID_MSB 3
`define NSR_GSEL_BIT 15
`define NSR_LIST_LSB 16
`define NSR_LIST_MSB 23
`define NSR_FLT_LSB 24
`define NSR_FLT_MSB 25
`define NSR_CTL_EN_BIT 0
`define NSR_FLD_PER_REG 16
// ==================================================================
// Reset values and responses
`define NSR_CTL_RST 1'h0
`define NSR_PERM_RST 32'h0000_0000
`define NSR_GRP_RST 16'h0000
`define NSR_RESP_OKAY 2'h0
`define NSR_RESP_SLVERR 2'h2
`endif

// File: inc/nsr_pkg.sv
// Types shared by the permission and request block
package nsr_pkg;
   // ===============================================================
   // Target filter modes
   typedef enum logic [1:0]
   {
      NSR_FLT_LIST = 2'h0,
      NSR_FLT_OTHERS = 2'h1,
      NSR_FLT_SELF = 2'h2,
      NSR_FLT_RSVD = 2'h3
   } nsr_filter_t;
   // Non-secure grants for one interrupt
   typedef struct packed {
      logic set_pend;
      logic sgi_gen;
      logic clr_pend;
      logic act_rd;
      logic tgt_rw;
   } nsr_grant_t;
   // One forwarded soft interrupt
   typedef struct packed {
      logic [3:0] id;
      logic [7:0] targets;
      logic [2:0] src;
   } nsr_sgi_t;
   // One register write handed from the bus slave
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic ns;
      logic [2:0] src;
   } nsr_wreq_t;
endpackage : nsr_pkg

// File: core/nsr_perm_check.sv
// Non-secure grant decode for one permission level
`timescale 1ns/1ps
module nsr_perm_check
   import nsr_pkg::*;
(
   input wire logic [1:0] level_in,
   input wire logic group1_in,
   input wire logic ns_in,
   output nsr_grant_t grant_out
);
   // ===============================================================
   // Secure or Group 1 accesses pass; levels are cumulative
   always_comb
   begin
      if (!ns_in || group1_in)
      begin
         grant_out = '1; // [RQ3]
      end
      else
      begin
         grant_out.set_pend = (level_in >= 2'h1); // [RQ4] [RQ5]
         grant_out.sgi_gen = (level_in >= 2'h1); // [RQ6]
         grant_out.clr_pend = (level_in >= 2'h2); // [RQ7]
         grant_out.act_rd = (level_in >= 2'h2); // [RQ7]
         grant_out.tgt_rw = (level_in == 2'h3); // [RQ8]
      end
   end
endmodule : nsr_perm_check

// File: core/nsr_axi_slave.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
`include "nsr_params.svh"
module nsr_axi_slave
   import nsr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [11:0] awaddr_in,
   input wire logic [2:0] awprot_in,
   input wire logic [2:0] src_cpu_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [11:0] araddr_in,
   input wire logic [2:0] arprot_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output nsr_wreq_t wreq_out,
   output logic wr_go_out,
   input wire logic wr_err_in,
   output logic [11:0] rd_addr_out,
   output logic rd_ns_out,
   output logic rd_go_out,
   input wire logic [31:0] rd_data_in,
   input wire logic rd_err_in
);
   logic aw_full_r;
   logic w_full_r;
   logic rd_pend_r;
   logic [11:0] aw_addr_r;
   logic aw_ns_r;
   logic [2:0] aw_src_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_take;
   logic w_take;
   assign aw_take = awvalid_in & awready_out;
   assign w_take = wvalid_in & wready_out;
   // Each half has its own process, so the struct is assembled here
   assign wreq_out = {aw_addr_r, w_data_r, w_strb_r, aw_ns_r, aw_src_r};
   // Both halves held and no response waiting
   assign wr_go_out = aw_full_r & w_full_r & ~bvalid_out;
   assign rd_go_out = rd_pend_r & ~rvalid_out;
   // ===============================================================
   // Write address; ready returns only after the response is taken
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         aw_full_r <= 1'b0;
         awready_out <= 1'b0;
      end
      else if (aw_take)
      begin
         aw_full_r <= 1'b1;
         awready_out <= 1'b0;
         aw_addr_r <= awaddr_in;
         aw_ns_r <= awprot_in[1];
         aw_src_r <= src_cpu_in;
      end
      else if (wr_go_out)
         aw_full_r <= 1'b0;
      else if (!aw_full_r && !bvalid_out)
         awready_out <= 1'b1;
   end
   // Write data, taken independently of the address
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         w_full_r <= 1'b0;
         wready_out <= 1'b0;
      end
      else if (w_take)
      begin
         w_full_r <= 1'b1;
         wready_out <= 1'b0;
         w_data_r <= wdata_in;
         w_strb_r <= wstrb_in;
      end
      else if (wr_go_out)
         w_full_r <= 1'b0;
      else if (!w_full_r && !bvalid_out)
         wready_out <= 1'b1;
   end
   // Write response
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         bvalid_out <= 1'b0;
         bresp_out <= `NSR_RESP_OKAY;
      end
      else if (wr_go_out)
      begin
         bvalid_out <= 1'b1;
         bresp_out <= wr_err_in ? `NSR_RESP_SLVERR : `NSR_RESP_OKAY;
      end
      else if (bready_in)
         bvalid_out <= 1'b0;
   end
   // Read address and data
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         rd_pend_r <= 1'b0;
         arready_out <= 1'b0;
         rvalid_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
         rresp_out <= `NSR_RESP_OKAY;
      end
      else
      begin
         if (arvalid_in && arready_out)
         begin
            rd_pend_r <= 1'b1;
            arready_out <= 1'b0;
            rd_addr_out <= araddr_in;
            rd_ns_out <= arprot_in[1];
         end
         else if (!rd_pend_r && !rvalid_out)
            arready_out <= 1'b1;
         if (rd_go_out)
         begin
            rd_pend_r <= 1'b0;
            rvalid_out <= 1'b1;
            rdata_out <= rd_data_in;
            rresp_out <= rd_err_in ? `NSR_RESP_SLVERR : `NSR_RESP_OKAY;
         end
         else if (rready_in)
            rvalid_out <= 1'b0;
      end
   end
endmodule : nsr_axi_slave

// File: core/nsr_top.sv
// Non-secure permission fields and soft interrupt request register
// Function
// RQ1 - Two-bit read-write permission per interrupt
// RQ2 - Non-configurable fields read zero, ignore writes
// RQ3 - Group 1 interrupts ignore permission field
// RQ4 - Level zero denies all Non-secure access
// RQ5 - Level one allows set-pending writes
// RQ6 - Level one allows Group 0 soft requests
// RQ7 - Level two adds clear-pending, active reads
// RQ8 - Level three adds processor-target access
// RQ9 - First register upper half reads zero
// RQ10 - Register index is interrupt number div 16
// RQ11 - Register n at E00 plus four n
// RQ12 - Requests dropped while forwarding disabled
// RQ13 - Request register shared by both states
// RQ14 - Group selector only with security extensions
// RQ15 - Request word field layout fixed
// RQ16 - Filter: list, others, self, reserved
// RQ17 - List bits pick interfaces; zero none
// RQ18 - Identifier names soft interrupt 0-15
// RQ19 - Non-secure request forwards only to Group 1; Group 0 targets also forwarded here at level one or above
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "nsr_params.svh"
module nsr_top
   import nsr_pkg::*;
#(
   parameter int NUM_INT = 64,
   parameter int NUM_CPU = 8,
   parameter bit SEC_EXT = 1'b1
)
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [11:0] awaddr_in,
   input wire logic [2:0] awprot_in,
   input wire logic [2:0] src_cpu_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [11:0] araddr_in,
   input wire logic [2:0] arprot_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   input wire logic [9:0] query_id_in,
   input wire logic query_group1_in,
   input wire logic query_ns_in,
   output nsr_grant_t query_grant_out,
   output logic sgi_valid_out,
   output nsr_sgi_t sgi_out
);
   localparam int NUM_REG = NUM_INT / `NSR_FLD_PER_REG;

   // ===============================================================
   // Storage
   logic [31:0] perm_r [NUM_REG];
   logic [15:0] grp_r [NUM_CPU];
   logic fwd_en_r;
   nsr_wreq_t wreq;
   logic wr_go;
   logic wr_err;
   logic [11:0] rd_addr;
   logic rd_ns;
   logic [31:0] rd_data;
   logic rd_err;

   // ===============================================================
   // Functions
   // Bits of register idx that hold a configurable field
   function automatic logic [31:0] impl_mask(input int idx);
      int m;
      logic [31:0] msk;
      msk = 32'h0000_0000;
      for (int f = 0; f < `NSR_FLD_PER_REG; f++)
      begin
         m = idx * `NSR_FLD_PER_REG + f; // [RQ10]
         // Low soft interrupts and shared ones only [RQ2] [RQ9]
         if ((m < 8) || ((m >= 32) && (m < NUM_INT)))
            msk[2*f +: 2] = 2'h3;
      end
      return msk;
   endfunction : impl_mask

   // Byte-lane merge restricted to implemented bits
   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb,
      input logic [31:0] msk);
      logic [31:0] be;
      be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~(be & msk)) | (new_v & be & msk);
   endfunction : merge

   // Permission register index for a byte offset, or -1
   function automatic int perm_index(input logic [11:0] addr);
      int ofs;
      ofs = int'(addr) - int'(`NSR_PERM_BASE);
      if ((ofs >= 0) && (ofs < 4 * NUM_REG) && (addr[1:0] == 2'h0))
         return ofs / 4; // [RQ11]
      return -1;
   endfunction : perm_index

   // Group register index for a byte offset, or -1
   function automatic int grp_index(input logic [11:0] addr);
      int ofs;
      ofs = int'(addr) - int'(`NSR_GRP_BASE);
      if ((ofs >= 0) && (ofs < 4 * NUM_CPU) && (addr[1:0] == 2'h0))
         return ofs / 4;
      return -1;
   endfunction : grp_index

   // Permission level of interrupt m; zero beyond the array
   function automatic logic [1:0] perm_level(input logic [9:0] m);
      logic [31:0] word;
      int idx;
      idx = int'(m) / `NSR_FLD_PER_REG; // [RQ10]
      if (idx >= NUM_REG)
         return 2'h0;
      word = perm_r[idx];
      return word[2 * (int'(m) % `NSR_FLD_PER_REG) +: 2];
   endfunction : perm_level

   // ===============================================================
   // Bus slave
   nsr_axi_slave u_slave (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .awvalid_in(awvalid_in),
      .awready_out(awready_out),
      .awaddr_in(awaddr_in),
      .awprot_in(awprot_in),
      .src_cpu_in(src_cpu_in),
      .wvalid_in(wvalid_in),
      .wready_out(wready_out),
      .wdata_in(wdata_in),
      .wstrb_in(wstrb_in),
      .bvalid_out(bvalid_out),
      .bready_in(bready_in),
      .bresp_out(bresp_out),
      .arvalid_in(arvalid_in),
      .arready_out(arready_out),
      .araddr_in(araddr_in),
      .arprot_in(arprot_in),
      .rvalid_out(rvalid_out),
      .rready_in(rready_in),
      .rdata_out(rdata_out),
      .rresp_out(rresp_out),
      .wreq_out(wreq),
      .wr_go_out(wr_go),
      .wr_err_in(wr_err),
      .rd_addr_out(rd_addr),
      .rd_ns_out(rd_ns),
      .rd_go_out(),
      .rd_data_in(rd_data),
      .rd_err_in(rd_err)
   );

   // ===============================================================
   // Write decode
   logic is_ctl_w;
   logic is_sgir_w;
   int perm_wi;
   int grp_wi;
   assign is_ctl_w = (wreq.addr == `NSR_CTL_OFS);
   assign is_sgir_w = (wreq.addr == `NSR_SGIR_OFS);
   assign perm_wi = perm_index(wreq.addr);
   assign grp_wi = grp_index(wreq.addr);
   // Unmapped offsets answer with a slave error
   assign wr_err = !(is_ctl_w || is_sgir_w || (perm_wi >= 0)
                     || (grp_wi >= 0));

   // Permission fields: Secure writes only, masked per field
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < NUM_REG; i++)
            perm_r[i] <= `NSR_PERM_RST;
      end
      else if (wr_go && !wreq.ns && (perm_wi >= 0))
         perm_r[perm_wi] <= merge(perm_r[perm_wi], wreq.data, // [RQ1]
            wreq.strb, impl_mask(perm_wi)); // [RQ2] [RQ9]
   end

   // Per-interface soft interrupt group bits, Secure only
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         for (int c = 0; c < NUM_CPU; c++)
            grp_r[c] <= `NSR_GRP_RST;
      end
      else if (wr_go && !wreq.ns && (grp_wi >= 0))
         grp_r[grp_wi] <= 16'(merge({16'h0000, grp_r[grp_wi]},
            wreq.data, wreq.strb, 32'h0000_FFFF));
   end

   // Forwarding enable, Secure only
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         fwd_en_r <= `NSR_CTL_RST;
      else if (wr_go && !wreq.ns && is_ctl_w && wreq.strb[0])
         fwd_en_r <= wreq.data[`NSR_CTL_EN_BIT];
   end

   // ===============================================================
   // Read decode; request register is write-only and reads zero
   int perm_ri;
   int grp_ri;
   assign perm_ri = perm_index(rd_addr);
   assign grp_ri = grp_index(rd_addr);
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (perm_ri >= 0)
      begin
         // Secure-only registers read zero to Non-secure
         if (!rd_ns)
            rd_data = perm_r[perm_ri]; // [RQ1]
      end
      else if (grp_ri >= 0)
      begin
         if (!rd_ns)
            rd_data = {16'h0000, grp_r[grp_ri]};
      end
      else if (rd_addr == `NSR_CTL_OFS)
      begin
         if (!rd_ns)
            rd_data = {31'h0000_0000, fwd_en_r};
      end
      else if (rd_addr != `NSR_SGIR_OFS)
         rd_err = 1'b1;
   end

   // ===============================================================
   // Soft interrupt request; one register for both states [RQ13]
   logic [3:0] req_id;
   logic [7:0] req_list;
   logic req_want1;
   nsr_filter_t req_flt;
   logic sgi_req;
   logic [7:0] filt_tgt;
   logic [7:0] fwd_tgt;
   logic [7:0] req_grp1;
   logic [1:0] sgi_lvl;
   nsr_grant_t sgi_grant;
   assign req_id = wreq.data[`NSR_ID_MSB:`NSR_ID_LSB]; // [RQ15] [RQ18]
   assign req_list = wreq.data[`NSR_LIST_MSB:`NSR_LIST_LSB]; // [RQ15]
   assign req_flt = nsr_filter_t'(wreq.data[`NSR_FLT_MSB:`NSR_FLT_LSB]);
   // Selector honoured only with the extensions present [RQ14]
   assign req_want1 = SEC_EXT & wreq.data[`NSR_GSEL_BIT];
   // Partial-lane writes are dropped so a torn word never fires
   assign sgi_req = wr_go && is_sgir_w && (wreq.strb == 4'hF);
   assign sgi_lvl = perm_level({6'h00, req_id});

   nsr_perm_check u_sgi_chk (
      .level_in(sgi_lvl),
      .group1_in(1'b0),
      .ns_in(wreq.ns),
      .grant_out(sgi_grant)
   );

   // Filter to a candidate target set
   always_comb
   begin
      unique case (req_flt)
         NSR_FLT_LIST: filt_tgt = req_list; // [RQ16] [RQ17]
         NSR_FLT_OTHERS: filt_tgt = ~(8'h01 << wreq.src); // [RQ16]
         NSR_FLT_SELF: filt_tgt = 8'h01 << wreq.src; // [RQ16]
         NSR_FLT_RSVD: filt_tgt = 8'h00;
      endcase
   end

   // Per-target group check
   always_comb
   begin
      fwd_tgt = 8'h00;
      req_grp1 = 8'h00;
      for (int c = 0; c < NUM_CPU; c++)
      begin
         req_grp1[c] = grp_r[c][req_id];
         if (wreq.ns)
            // Group 1 always; Group 0 only when granted [RQ6] [RQ19]
            fwd_tgt[c] = filt_tgt[c] & (grp_r[c][req_id]
                         | sgi_grant.sgi_gen);
         else
            fwd_tgt[c] = filt_tgt[c] & (grp_r[c][req_id] == req_want1);
      end
   end

   // Forwarded request pulse; no pulse while disabled, but sgi_out still latches each request
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         sgi_valid_out <= 1'b0;
         sgi_out <= '0;
      end
      else
      begin
         sgi_valid_out <= sgi_req && fwd_en_r && (fwd_tgt != 8'h00); // [RQ12]
         if (sgi_req)
         begin
            sgi_out.id <= req_id; // [RQ18]
            sgi_out.targets <= fwd_tgt;
            sgi_out.src <= wreq.src;
         end
      end
   end

   // ===============================================================
   // Grant query for the neighbouring pending, active, target logic
   nsr_grant_t q_grant;
   logic [1:0] q_lvl;
   assign q_lvl = perm_level(query_id_in);
   nsr_perm_check u_query_chk (
      .level_in(q_lvl),
      .group1_in(query_group1_in),
      .ns_in(query_ns_in),
      .grant_out(q_grant)
   );

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         query_grant_out <= '0;
      else
         query_grant_out <= q_grant; // [RQ3] [RQ4] [RQ8]
   end

   // ===============================================================
   // Checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence sgir_write_s;
      wr_go && is_sgir_w && (wreq.strb == 4'hF);
   endsequence

   sequence self_only_s;
      sgir_write_s ##0 (req_flt == NSR_FLT_SELF);
   endsequence

   perm_upper_zero_a: assert property (perm_r[0][31:16] == 16'h0000) // [RQ9]
      else $error("permission upper half not zero");

   perm_write_a: assert property ( // [RQ11]
      (wr_go && !wreq.ns && perm_wi == 2 && wreq.strb == 4'hF)
      |=> perm_r[2] == ($past(wreq.data) & impl_mask(2)))
      else $error("permission write lost");

   perm_ns_ign_a: assert property ( // [RQ1]
      (wr_go && wreq.ns) |=> $stable(perm_r[0]))
      else $error("non-secure write changed permission");

   lvl0_deny_a: assert property ( // [RQ4]
      (query_ns_in && !query_group1_in
       && perm_level(query_id_in) == 2'h0)
      |=> query_grant_out == '0)
      else $error("level zero granted access");

   grp1_ignore_a: assert property ( // [RQ3]
      query_group1_in |=> query_grant_out == '1)
      else $error("group 1 access refused");

   tgt_lvl3_a: assert property ( // [RQ8]
      (query_ns_in && !query_group1_in)
      |=> query_grant_out.tgt_rw
          == ($past(q_lvl) == 2'h3))
      else $error("target grant level wrong");

   sgi_disabled_a: assert property ( // [RQ12]
      !fwd_en_r |=> !sgi_valid_out)
      else $error("request forwarded while disabled");

   sgi_self_a: assert property ( // [RQ16]
      self_only_s |=> !sgi_valid_out
      || sgi_out.targets == (8'h01 << $past(wreq.src)))
      else $error("self filter reached others");

   sgi_empty_a: assert property ( // [RQ17]
      (sgir_write_s ##0 (req_flt == NSR_FLT_LIST) ##0 (req_list == 8'h00))
      |=> !sgi_valid_out)
      else $error("empty list forwarded");

   ns_group1_a: assert property ( // [RQ19]
      (sgir_write_s ##0 wreq.ns ##0 (sgi_lvl == 2'h0))
      |-> (fwd_tgt & ~req_grp1) == 8'h00 ##1
          (!sgi_valid_out || (sgi_out.targets & ~$past(req_grp1)) == 8'h00))
      else $error("non-secure request hit group 0");

endmodule : nsr_top

// File: sim/nsr_cpu_model.sv
// Behavioural CPU interface side that takes forwarded soft interrupts
`timescale 1ns/1ps
module nsr_cpu_model
   import nsr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic sgi_valid_in,
   input wire nsr_sgi_t sgi_in,
   output logic [15:0] count_out,
   output nsr_sgi_t last_out
);
   // The pulse lasts one cycle, so a missed edge would lose an interrupt
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         count_out <= 16'h0000;
         last_out <= '0;
      end
      else if (sgi_valid_in)
      begin
         count_out <= count_out + 16'h0001;
         last_out <= sgi_in;
      end
   end
endmodule : nsr_cpu_model

// File: sim/tb.sv
// Self-checking bench for the permission and request block
`timescale 1ns/1ps
module tb;
   import nsr_pkg::*;
   // ==============================================================
   // Signals and reference state
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, qg1 = 1'b0, qns = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, sgi_valid;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [2:0] awprot = 3'h0, arprot = 3'h0, src = 3'h0;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'h67D2;
   logic [1:0] bresp, rresp;
   logic [9:0] qid = 10'h000;
   nsr_grant_t grant;
   nsr_sgi_t software_generated_int, plast;
   logic [15:0] pcount, c0;
   logic [31:0] perm [4];
   logic [15:0] grp [8];
   int errors = 0, comparisons = 0;

   always #50 clk_sys_in = ~clk_sys_in;

   nsr_top nsr_top_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr),
      .awprot_in(awprot), .src_cpu_in(src), .wvalid_in(wvalid),
      .wready_out(wready), .wdata_in(wdata), .wstrb_in(4'hF),
      .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
      .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
      .arprot_in(arprot), .rvalid_out(rvalid), .rready_in(rready),
      .rdata_out(rdata), .rresp_out(rresp), .query_id_in(qid),
      .query_group1_in(qg1), .query_ns_in(qns),
      .query_grant_out(grant), .sgi_valid_out(sgi_valid),
      .sgi_out(software_generated_int));

   nsr_cpu_model nsr_cpu_model_i (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .sgi_valid_in(sgi_valid), .sgi_in(software_generated_int),
      .count_out(pcount), .last_out(plast));

   // ==============================================================
   // Helpers
   task automatic wrap_up;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Sampling at the falling edge keeps the handshake free of races
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic ns, input logic [2:0] s, output logic [1:0] resp);
      int n;
      logic ta, tw, tb_done;
      n = 0;
      tb_done = 1'b0;
      @(posedge clk_sys_in);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awaddr <= a;
      wdata <= d;
      src <= s;
      awprot <= {1'b0, ns, 1'b0};
      while (!tb_done && n < 60)
      begin
         @(negedge clk_sys_in);
         ta = awvalid && awready === 1'b1;
         tw = wvalid && wready === 1'b1;
         tb_done = bvalid === 1'b1;
         resp = bresp;
         @(posedge clk_sys_in);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb_done)
            bready <= 1'b0;
         n++;
      end
      if (!tb_done)
      begin
         errors++;
         wrap_up();
      end
      @(negedge clk_sys_in);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic ns,
      output logic [31:0] d, output logic [1:0] resp);
      int n;
      logic ta, td;
      n = 0;
      td = 1'b0;
      @(posedge clk_sys_in);
      arvalid <= 1'b1;
      rready <= 1'b1;
      araddr <= a;
      arprot <= {1'b0, ns, 1'b0};
      while (!td && n < 60)
      begin
         @(negedge clk_sys_in);
         ta = arvalid && arready === 1'b1;
         td = rvalid === 1'b1;
         d = rdata;
         resp = rresp;
         @(posedge clk_sys_in);
         if (ta)
            arvalid <= 1'b0;
         if (td)
            rready <= 1'b0;
         n++;
      end
      if (!td)
      begin
         errors++;
         wrap_up();
      end
   endtask : rd

   // Grants appear one edge after the query inputs
   task automatic query(input logic [9:0] m, input logic g1,
      output logic [31:0] g);
      @(posedge clk_sys_in);
      qid <= m;
      qg1 <= g1;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      g = 32'(grant);
   endtask : query

   function automatic logic [31:0] grant_exp(input logic [1:0] l);
      return {27'h0, l != 2'h0, l != 2'h0, l[1], l[1], l == 2'h3};
   endfunction : grant_exp

   // Targets that should survive filter, group and permission checks
   function automatic logic [7:0] sgi_exp(input logic [31:0] w,
      input logic ns, input logic [2:0] s);
      logic [7:0] cand;
      logic [7:0] t;
      logic [1:0] l;
      l = perm[0][2 * w[3:0] +: 2];
      case (w[25:24])
         2'h0: cand = w[23:16];
         2'h1: cand = ~(8'h01 << s);
         2'h2: cand = 8'h01 << s;
         default: cand = 8'h00;
      endcase
      for (int c = 0; c < 8; c++)
         t[c] = cand[c] && (ns ? (grp[c][w[3:0]] || l != 2'h0)
            : grp[c][w[3:0]] == w[15]);
      return t;
   endfunction : sgi_exp

   // ==============================================================
   // Main sequence
   initial
   begin
      logic [31:0] d, v, g;
      logic [7:0] t;
      logic [1:0] r;
      logic ns;
      repeat (5) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      rd(12'hE08, 1'b0, d, r);
      chk(d, 32'h0);
      rd(12'h400, 1'b0, d, r);
      chk(32'(r), 32'h2);
      c0 = pcount;
      wr(12'hF00, 32'h0200_0000, 1'b0, 3'h1, r);
      chk(32'(pcount - c0), 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         v = (i == 2) ? (rnd() << 4) | 32'hC : rnd();
         wr(12'hE00 + 12'(4 * i), v, 1'b0, 3'h0, r);
         chk(32'(r), 32'h0);
         perm[i] = v & (i == 0 ? 32'h0000FFFF : i == 1 ? 32'h0 : 32'hFFFFFFFF);
         rd(12'hE00 + 12'(4 * i), 1'b0, d, r);
         chk(d, perm[i]);
      end
      for (int m = 0; m < 64; m++)
      begin
         query(10'(m), 1'b0, g);
         r = perm[m / 16][2 * (m % 16) +: 2];
         chk(g, grant_exp(r));
      end
      for (int m = 32; m < 48; m++)
      begin
         query(10'(m), 1'b1, g);
         chk(g, grant_exp(2'h3));
      end
      // Secure access passes whatever the field holds
      @(posedge clk_sys_in);
      qns <= 1'b0;
      query(10'd16, 1'b0, g);
      chk(g, grant_exp(2'h3));
      wr(12'h000, 32'h1, 1'b0, 3'h0, r);
      for (int c = 0; c < 8; c++)
      begin
         grp[c] = 16'(rnd());
         wr(12'h080 + 12'(4 * c), 32'(grp[c]), 1'b0, 3'h0, r);
      end
      // Random requests with an empty list and the reserved filter first
      for (int k = 0; k < 48; k++)
      begin
         v = rnd();
         if (k == 0)
            v[25:16] = 10'h000;
         if (k == 1)
            v[25:24] = 2'h3;
         ns = 1'(rnd() >> 9);
         c0 = pcount;
         wr(12'hF00, v, ns, v[30:28], r);
         t = sgi_exp(v, ns, v[30:28]);
         d = 32'(pcount - c0);
         chk(d, 32'(t != 8'h00));
         g = 32'({v[3:0], t, v[30:28]});
         if (t != 8'h00)
            chk(32'(plast), g);
      end
      wrap_up();
   end
endmodule : tb
